// ### logic/fsk_modulation_control.sv
// Transmit FSK modulation control: scheme decode, divider-set choice and waveform shaper.
// Assumes an AXI4-Lite master on aclk and a transmit data pin asynchronous to aclk.
`timescale 1ns/10ps
module fsk_modulation_control
  import fsk_mod_pkg::*;
(
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite slave.
  input  wire logic [ADDR_W-1:0]         s_axi_awaddr,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  input  wire logic [ADDR_W-1:0]         s_axi_araddr,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // Transmit data pin and synthesizer / shaper controls.
  input  wire logic                      tx_bit_input,
  output fsk_mod_pkg::divider_set_t      synth_set,
  output logic                           vco_mode,
  output logic                           divider_mode,
  output logic                           mod_clk_tick,
  output fsk_mod_pkg::shaper_state_t     shaper_state,
  output logic [SLOPE_W-1:0]             slope_code,
  output logic [ATTEN_W-1:0]             atten_code,
  output logic [FILT_W-1:0]              filter_code
);

  import fsk_mod_pkg::*;

  typedef enum logic [0:0] {
    SHP_HOLD = 1'b0,
    SHP_RAMP = 1'b1
  } shp_fsm_t;

  // Merges a write into an old register value under the byte strobes.
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // True for any offset that maps to a register, readable or writable.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    return (a == OFS_SCHEME) || (a == OFS_ZERO_SET) || (a == OFS_ONE_SET) ||
           (a == OFS_SHAPER) || (a == OFS_STATUS);
  endfunction

  function automatic divider_set_t unpack_set(input logic [31:0] r);
    divider_set_t s;
    s.swallow_count = r[SET_SWALLOW_LSB +: SWALLOW_W];
    s.main_count    = r[SET_MAIN_LSB +: MAIN_W];
    s.ref_divider   = r[SET_REF_LSB +: REFDIV_W];
    return s;
  endfunction

  // Register state.
  logic [1:0]         scheme_ff;
  logic [31:0]        zero_set_ff;
  logic [31:0]        one_set_ff;
  logic [31:0]        shaper_reg_ff;
  logic [1:0]         nxt_scheme;
  logic [31:0]        nxt_zero_set;
  logic [31:0]        nxt_one_set;
  logic [31:0]        nxt_shaper_reg;

  // Bus handshake state.
  logic               bvalid_ff;
  logic [1:0]         bresp_ff;
  logic               rvalid_ff;
  logic [1:0]         rresp_ff;
  logic [31:0]        rdata_ff;
  logic               nxt_bvalid;
  logic [1:0]         nxt_bresp;
  logic               nxt_rvalid;
  logic [1:0]         nxt_rresp;
  logic [31:0]        nxt_rdata;
  logic               wr_fire;
  logic               rd_fire;

  // Datapath state.
  logic               tx_bit;
  logic               tick;
  shaper_cfg_t        cfg;
  divider_set_t       zero_set;
  divider_set_t       one_set;
  shp_fsm_t           shp_ff;
  shp_fsm_t           nxt_shp;
  logic               level_ff;
  logic               nxt_level;
  logic [STEP_W-1:0]  step_ff;
  logic [STEP_W-1:0]  nxt_step;
  logic               sampled_ff;
  logic               nxt_sampled;
  logic               tone_ff;
  logic               nxt_tone;
  logic               is_vco;
  logic               is_div;
  logic [31:0]        status_word;

  pin_sync u_tx_sync (
    .aclk    (aclk),
    .aresetn (aresetn),
    .pin     (tx_bit_input),
    .level   (tx_bit)
  );

  always_comb begin
    cfg.ref_divisor           = shaper_reg_ff[SHP_KDIV_LSB +: KDIV_W];
    cfg.shaper_clock_exponent = shaper_reg_ff[SHP_EXP_LSB +: EXP_W];
    cfg.slope_code            = shaper_reg_ff[SHP_SLOPE_LSB +: SLOPE_W];
    cfg.atten_code            = shaper_reg_ff[SHP_ATTEN_LSB +: ATTEN_W];
    cfg.filter_code           = shaper_reg_ff[SHP_FILT_LSB +: FILT_W];
    zero_set                  = unpack_set(zero_set_ff);
    one_set                   = unpack_set(one_set_ff);
  end

  mod_clock_divider u_mod_clk (
    .aclk           (aclk),
    .aresetn        (aresetn),
    .ref_divisor    (cfg.ref_divisor),
    .clock_exponent (cfg.shaper_clock_exponent),
    .tick           (tick)
  );

  // Scheme decode; unused codes leave both modes off and the zero set in place.
  assign is_vco = (scheme_ff == SCHEME_VCO);
  assign is_div = (scheme_ff == SCHEME_DIV);

  // Write channel: address and data are taken together, one write at a time.
  assign wr_fire       = s_axi_awvalid && s_axi_wvalid && !bvalid_ff;
  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign rd_fire       = s_axi_arvalid && !rvalid_ff;
  assign s_axi_arready = rd_fire;

  always_comb begin
    nxt_scheme     = scheme_ff;
    nxt_zero_set   = zero_set_ff;
    nxt_one_set    = one_set_ff;
    nxt_shaper_reg = shaper_reg_ff;
    nxt_bvalid     = bvalid_ff && !s_axi_bready;
    nxt_bresp      = bresp_ff;
    if (wr_fire) begin
      nxt_bvalid = 1'b1;
      nxt_bresp  = RESP_OKAY;
      case (s_axi_awaddr)
        OFS_SCHEME: begin
          nxt_scheme = 2'(merge_bytes({30'h0, scheme_ff}, s_axi_wdata, s_axi_wstrb));
        end
        OFS_ZERO_SET: begin
          nxt_zero_set = merge_bytes(zero_set_ff, s_axi_wdata, s_axi_wstrb);
        end
        OFS_ONE_SET: begin
          nxt_one_set = merge_bytes(one_set_ff, s_axi_wdata, s_axi_wstrb);
        end
        OFS_SHAPER: begin
          nxt_shaper_reg = merge_bytes(shaper_reg_ff, s_axi_wdata, s_axi_wstrb);
        end
        OFS_STATUS: begin
          // Status is read-only; the write is accepted and ignored.
          nxt_bresp = RESP_OKAY;
        end
        default: begin
          nxt_bresp = RESP_SLVERR;
        end
      endcase
    end
  end

  always_comb begin
    status_word                        = '0;
    status_word[ST_BIT_LSB]            = tx_bit;
    status_word[ST_TONE_LSB]           = tone_ff;
    status_word[ST_LEVEL_LSB]          = level_ff;
    status_word[ST_RAMP_LSB]           = (shp_ff == SHP_RAMP);
    status_word[ST_STEP_LSB +: STEP_W] = step_ff;
    status_word[ST_VCO_LSB]            = is_vco;
    status_word[ST_DIVM_LSB]           = is_div;
  end

  always_comb begin
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rresp  = rresp_ff;
    nxt_rdata  = rdata_ff;
    if (rd_fire) begin
      nxt_rvalid = 1'b1;
      nxt_rresp  = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      case (s_axi_araddr)
        OFS_SCHEME:   nxt_rdata = {30'h0, scheme_ff};
        OFS_ZERO_SET: nxt_rdata = zero_set_ff;
        OFS_ONE_SET:  nxt_rdata = one_set_ff;
        OFS_SHAPER:   nxt_rdata = shaper_reg_ff;
        OFS_STATUS:   nxt_rdata = status_word;
        default:      nxt_rdata = '0;
      endcase
    end
  end

  // Tone select follows the synchronised bit only in divider mode.
  always_comb begin
    nxt_tone = 1'b0;
    if (is_div) begin
      nxt_tone = tx_bit;
    end
  end

  // Waveform shaper: in vco mode bits are sampled on modulator clock ticks; otherwise every cycle.
  always_comb begin
    nxt_shp     = shp_ff;
    nxt_level   = level_ff;
    nxt_step    = step_ff;
    nxt_sampled = sampled_ff;
    if (!is_vco) begin
      nxt_shp     = SHP_HOLD;
      nxt_step    = '0;
      nxt_sampled = tx_bit;
      nxt_level   = tx_bit;
    end else if (tick) begin
      nxt_sampled = tx_bit;
      if (tx_bit != sampled_ff) begin
        // A change mid-ramp turns the ramp round and restarts the count.
        nxt_shp   = SHP_RAMP;
        nxt_level = tx_bit;
        nxt_step  = '0;
      end else begin
        case (shp_ff)
          SHP_HOLD: begin
            nxt_step = '0;
          end
          SHP_RAMP: begin
            if (step_ff == STEP_LAST) begin
              nxt_shp  = SHP_HOLD;
              nxt_step = '0;
            end else begin
              nxt_step = step_ff + STEP_W'(1);
            end
          end
          default: begin
            nxt_shp  = SHP_HOLD;
            nxt_step = '0;
          end
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      scheme_ff     <= SCHEME_VCO;
      zero_set_ff   <= SET_RESET;
      one_set_ff    <= SET_RESET;
      shaper_reg_ff <= {26'h0, KDIV_RESET};
      bvalid_ff     <= 1'b0;
      bresp_ff      <= RESP_OKAY;
      rvalid_ff     <= 1'b0;
      rresp_ff      <= RESP_OKAY;
      rdata_ff      <= '0;
      shp_ff        <= SHP_HOLD;
      level_ff      <= 1'b0;
      step_ff       <= '0;
      sampled_ff    <= 1'b0;
      tone_ff       <= 1'b0;
    end else begin
      scheme_ff     <= nxt_scheme;
      zero_set_ff   <= nxt_zero_set;
      one_set_ff    <= nxt_one_set;
      shaper_reg_ff <= nxt_shaper_reg;
      bvalid_ff     <= nxt_bvalid;
      bresp_ff      <= nxt_bresp;
      rvalid_ff     <= nxt_rvalid;
      rresp_ff      <= nxt_rresp;
      rdata_ff      <= nxt_rdata;
      shp_ff        <= nxt_shp;
      level_ff      <= nxt_level;
      step_ff       <= nxt_step;
      sampled_ff    <= nxt_sampled;
      tone_ff       <= nxt_tone;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp  = rresp_ff;
  assign s_axi_rdata  = rdata_ff;

  // The tone flop lags the scheme by a cycle, so the mode gates it here as well.
  assign synth_set          = (tone_ff && is_div) ? one_set : zero_set;
  assign vco_mode           = is_vco;
  assign divider_mode       = is_div;
  assign mod_clk_tick       = tick;
  assign shaper_state       = {(shp_ff == SHP_RAMP), level_ff, step_ff};
  // Codes pass unchanged; their full ranges are legal.
  assign slope_code  = cfg.slope_code;
  assign atten_code  = cfg.atten_code;
  assign filter_code = cfg.filter_code;

endmodule // fsk_modulation_control

// ### logic/fsk_mod_pkg.sv
// Shared constants and carrier types for the transmit modulation control block.
// Assumes a 32-bit AXI4-Lite register bus and one clock that stands for the crystal clock.
package fsk_mod_pkg;

  localparam int unsigned SWALLOW_W = 4;
  localparam int unsigned MAIN_W    = 12;
  localparam int unsigned REFDIV_W  = 12;
  localparam int unsigned KDIV_W    = 6;
  localparam int unsigned EXP_W     = 3;
  localparam int unsigned SLOPE_W   = 5;
  localparam int unsigned ATTEN_W   = 4;
  localparam int unsigned FILT_W    = 3;
  localparam int unsigned STEP_W    = 2;
  localparam int unsigned DIVCNT_W  = 13;
  localparam int unsigned ADDR_W    = 8;

  // Register byte offsets.
  localparam logic [ADDR_W-1:0] OFS_SCHEME   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_ZERO_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_ONE_SET  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_SHAPER   = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_STATUS   = 8'h10;

  // Field positions of the divider-set registers.
  localparam int unsigned SET_SWALLOW_LSB = 0;
  localparam int unsigned SET_MAIN_LSB    = 8;
  localparam int unsigned SET_REF_LSB     = 20;

  // Field positions of the shaper register.
  localparam int unsigned SHP_KDIV_LSB  = 0;
  localparam int unsigned SHP_EXP_LSB   = 8;
  localparam int unsigned SHP_SLOPE_LSB = 12;
  localparam int unsigned SHP_ATTEN_LSB = 20;
  localparam int unsigned SHP_FILT_LSB  = 24;

  // Field positions of the status register.
  localparam int unsigned ST_BIT_LSB    = 0;
  localparam int unsigned ST_TONE_LSB   = 1;
  localparam int unsigned ST_LEVEL_LSB  = 2;
  localparam int unsigned ST_RAMP_LSB   = 3;
  localparam int unsigned ST_STEP_LSB   = 4;
  localparam int unsigned ST_VCO_LSB    = 8;
  localparam int unsigned ST_DIVM_LSB   = 9;

  localparam logic [1:0] SCHEME_VCO = 2'b00;
  localparam logic [1:0] SCHEME_DIV = 2'b10;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [EXP_W-1:0]    EXP_MAX    = 3'h7;
  localparam logic [STEP_W-1:0]   STEP_LAST  = 2'h3;
  localparam logic [KDIV_W-1:0]   KDIV_RESET = 6'h01;
  localparam logic [31:0]         SET_RESET  = 32'h00101000;

  typedef struct packed {
    logic [SWALLOW_W-1:0] swallow_count;
    logic [MAIN_W-1:0]    main_count;
    logic [REFDIV_W-1:0]  ref_divider;
  } divider_set_t;

  typedef struct packed {
    logic [KDIV_W-1:0]  ref_divisor;
    logic [EXP_W-1:0]   shaper_clock_exponent;
    logic [SLOPE_W-1:0] slope_code;
    logic [ATTEN_W-1:0] atten_code;
    logic [FILT_W-1:0]  filter_code;
  } shaper_cfg_t;

  typedef struct packed {
    logic              active;
    logic              level;
    logic [STEP_W-1:0] step;
  } shaper_state_t;

endpackage

// ### logic/pin_sync.sv
// Three-stage synchroniser for an asynchronous input pin.
// The output only follows the pin once the second and third stages agree.
`timescale 1ns/10ps
module pin_sync (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic pin,
  output logic      level
);

  logic meta_ff;
  logic s2_ff;
  logic s3_ff;
  logic level_ff;
  logic nxt_level;

  always_comb begin
    nxt_level = (s2_ff == s3_ff) ? s3_ff : level_ff;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff  <= 1'b0;
      s2_ff    <= 1'b0;
      s3_ff    <= 1'b0;
      level_ff <= 1'b0;
    end else begin
      meta_ff  <= pin;
      s2_ff    <= meta_ff;
      s3_ff    <= s2_ff;
      level_ff <= nxt_level;
    end
  end

  assign level = level_ff;

endmodule // pin_sync

// ### logic/mod_clock_divider.sv
// Modulator clock divider: one aclk-wide tick every divisor * 2^(7 - exponent) cycles.
// Assumes aclk is the crystal clock; the divisor and exponent may change at any time.
`timescale 1ns/10ps
module mod_clock_divider
  import fsk_mod_pkg::*;
(
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic [KDIV_W-1:0]   ref_divisor,
  input  wire logic [EXP_W-1:0]    clock_exponent,
  output logic                     tick
);

  logic [DIVCNT_W-1:0] count_ff;
  logic [DIVCNT_W-1:0] nxt_count;
  logic [DIVCNT_W-1:0] period;
  logic [KDIV_W-1:0]   divisor;
  logic                tick_ff;
  logic                nxt_tick;

  always_comb begin
    // A divisor of zero is outside the legal range and acts as one.
    divisor   = (ref_divisor == '0) ? KDIV_RESET : ref_divisor;
    period    = DIVCNT_W'({7'h00, divisor} << (EXP_MAX - clock_exponent));
    nxt_tick  = 1'b0;
    nxt_count = count_ff + DIVCNT_W'(1);
    // Comparing with >= lets a shortened period take effect at once.
    if (nxt_count >= period) begin
      nxt_count = '0;
      nxt_tick  = 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_ff <= '0;
      tick_ff  <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      tick_ff  <= nxt_tick;
    end
  end

  assign tick = tick_ff;

endmodule // mod_clock_divider

// ### verification/fsk_ctrl_sva.sv
// Assertion checker for the transmit modulation control block.
// Assumes one clock domain with a synchronous active-low reset; bound to the top module.
`timescale 1ns/10ps
module fsk_ctrl_sva
  import fsk_mod_pkg::*;
(
  input wire logic                          aclk,
  input wire logic                          aresetn,
  input wire logic                          s_axi_awvalid,
  input wire logic                          s_axi_awready,
  input wire logic                          s_axi_bvalid,
  input wire logic                          s_axi_arvalid,
  input wire logic                          s_axi_arready,
  input wire logic                          s_axi_rvalid,
  input wire fsk_mod_pkg::divider_set_t     synth_set,
  input wire logic                          vco_mode,
  input wire logic                          divider_mode,
  input wire logic                          mod_clk_tick,
  input wire fsk_mod_pkg::shaper_state_t    shaper_state
);
  import fsk_mod_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_modes_exclusive: assert property (!(vco_mode && divider_mode))
    else $error("both modulation modes decoded at once");
  a_vco_set_fixed: assert property (
    vco_mode && !(s_axi_awvalid && s_axi_awready) |=> !vco_mode || $stable(synth_set))
    else $error("synthesizer set moved in vco mode");
  a_idle_other: assert property (
    !vco_mode ##1 !vco_mode |-> !shaper_state.active && shaper_state.step == 2'h0)
    else $error("shaper ramps outside vco mode");
  a_hold_no_tick: assert property (
    vco_mode && !mod_clk_tick ##1 vco_mode |-> $stable(shaper_state))
    else $error("shaper moved without a modulator tick");
  a_ramp_start: assert property (
    vco_mode && $rose(shaper_state.active) |-> shaper_state.step == 2'h0 && $past(mod_clk_tick))
    else $error("ramp began off a tick or not at step zero");
  a_step_advance: assert property (
    vco_mode && shaper_state.active && mod_clk_tick && shaper_state.step != STEP_LAST
    ##1 vco_mode |-> shaper_state.active
    && (shaper_state.step == $past(shaper_state.step) + 2'h1 || shaper_state.step == 2'h0))
    else $error("ramp step did not advance on a tick");
  a_ramp_end: assert property (
    vco_mode && shaper_state.active && mod_clk_tick && shaper_state.step == STEP_LAST
    ##1 vco_mode |-> !shaper_state.active || shaper_state.step == 2'h0)
    else $error("ramp ran past four steps");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready |=> s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
endmodule // fsk_ctrl_sva

bind fsk_modulation_control fsk_ctrl_sva u_sva (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .synth_set,
  .vco_mode, .divider_mode, .mod_clk_tick, .shaper_state);

// ### verification/host_bit_source.sv
// Host model that shifts a sixteen-bit frame onto the transmit data pin, first bit first.
// Assumes the bench picks DC-balanced frames; the pin stays driven at the last bit between frames.
`timescale 1ns/10ps
module host_bit_source (
  input  wire logic        aclk,
  input  wire logic        start,
  input  wire logic [15:0] pattern,
  input  wire logic [7:0]  hold,
  output logic             tx_bit,
  output logic             busy
);
  logic [15:0] shift_ff;
  logic [4:0]  left_ff;
  logic [7:0]  cnt_ff;

  initial begin
    tx_bit = 1'b0;
    busy = 1'b0;
  end

  always @(posedge aclk) begin
    if (start && !busy) begin
      tx_bit <= pattern[15];
      shift_ff <= pattern << 1;
      left_ff <= 5'h0f;
      cnt_ff <= hold - 8'h01;
      busy <= 1'b1;
    end else if (busy) begin
      if (cnt_ff != 8'h00) begin
        cnt_ff <= cnt_ff - 8'h01;
      end else if (left_ff == 5'h00) begin
        busy <= 1'b0;
      end else begin
        tx_bit <= shift_ff[15];
        shift_ff <= shift_ff << 1;
        left_ff <= left_ff - 5'h01;
        cnt_ff <= hold - 8'h01;
      end
    end
  end
endmodule // host_bit_source

// ### verification/testbench.sv
// Self-checking bench: AXI4-Lite register access plus a host model on the data pin.
// Assumes the checker is bound separately and a 25 MHz clock standing for the crystal.
`timescale 1ns/10ps
module testbench;
  import fsk_mod_pkg::*;
  localparam logic [31:0] ONE_EXP  = {4'h0, 4'h7, 12'h456, 12'h123};
  localparam logic [31:0] ZERO_EXP = {4'h0, 4'h0, 12'h010, 12'h001};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic tx_bit_input, vco_mode, divider_mode, mod_clk_tick, frame_start, frame_busy;
  divider_set_t synth_set;
  shaper_state_t shaper_state;
  logic [SLOPE_W-1:0] slope_code;
  logic [ATTEN_W-1:0] atten_code;
  logic [FILT_W-1:0] filter_code;
  logic [15:0] frame_bits;
  logic [7:0] frame_hold;
  int error_cnt = 0, compares = 0, cycles = 0, run_len = 0, ramps = 0, bad_runs = 0, exp_run = 4;

  fsk_modulation_control dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .tx_bit_input, .synth_set, .vco_mode, .divider_mode,
    .mod_clk_tick, .shaper_state, .slope_code, .atten_code, .filter_code);
  host_bit_source host (.aclk, .start(frame_start), .pattern(frame_bits), .hold(frame_hold),
    .tx_bit(tx_bit_input), .busy(frame_busy));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  task test_done;
    $display("comparisons %0d, mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_p, w_p;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    aw_p = 1'b1;
    w_p = 1'b1;
    while (aw_p || w_p) begin
      @(posedge aclk);
      if (aw_p && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_p = 1'b0;
      end
      if (w_p && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_p = 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    s_axi_bready <= 1'b0;
    check("write response", s_axi_bresp, er);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    s_axi_rready <= 1'b0;
    check("read data", s_axi_rdata, ed);
    check("read response", s_axi_rresp, er);
  endtask

  task automatic send(input logic [15:0] bits, input logic [7:0] hold);
    @(posedge aclk);
    frame_bits <= bits;
    frame_hold <= hold;
    frame_start <= 1'b1;
    @(posedge aclk);
    frame_start <= 1'b0;
    // Let the model raise busy before any caller waits for it to fall.
    @(posedge aclk);
  endtask

  task automatic tick_gap(output int n);
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (mod_clk_tick !== 1'b1);
  endtask

  // Ramp lengths are tallied from the shaper's own active flag, one run per transition.
  always @(posedge aclk) begin
    if (shaper_state.active === 1'b1) run_len <= run_len + 1;
    else begin
      if (run_len != 0) begin
        ramps <= ramps + 1;
        if (run_len != exp_run) bad_runs <= bad_runs + 1;
      end
      run_len <= 0;
    end
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      $display("test run timed out");
      test_done;
    end
  end

  initial begin
    int n;
    int dv[4] = '{3, 1, 63, 1};
    int ex[4] = '{5, 0, 7, 7};
    logic [31:0] wv[2] = '{32'hffffffd5, 32'h00000001};
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, frame_bits, frame_hold, frame_start} = '0;
    s_axi_wstrb = 4'hf;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_SCHEME, 32'h0, RESP_OKAY);
    rd(OFS_ZERO_SET, SET_RESET, RESP_OKAY);
    rd(OFS_ONE_SET, SET_RESET, RESP_OKAY);
    rd(OFS_SHAPER, 32'(KDIV_RESET), RESP_OKAY);
    rd(8'h14, 32'h0, RESP_SLVERR);
    wr(8'h14, 32'h5, RESP_SLVERR);
    wr(OFS_STATUS, 32'h3, RESP_OKAY);
    $display("test reset and map finished");
    wr(OFS_ONE_SET, 32'h12345607, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SCHEME, 32'(i), RESP_OKAY);
      send(16'hff00, 8'd20);
      repeat (80) @(posedge aclk);
      check("set for one", synth_set, (i == 2) ? ONE_EXP : ZERO_EXP);
      check("vco mode", vco_mode, i == 0);
      check("divider mode", divider_mode, i == 2);
      repeat (160) @(posedge aclk);
      check("set for zero", synth_set, ZERO_EXP);
      while (frame_busy !== 1'b0) @(posedge aclk);
    end
    $display("test scheme decode finished");
    wr(OFS_SCHEME, 32'(SCHEME_VCO), RESP_OKAY);
    for (int k = 1; k <= 2; k++) begin
      wr(OFS_SHAPER, 32'h700 | 32'(k), RESP_OKAY);
      repeat (20) @(posedge aclk);
      exp_run = 4 * k;
      ramps = 0;
      bad_runs = 0;
      send(16'h5a5a, 8'(16 * k));
      while (frame_busy !== 1'b0) @(posedge aclk);
      repeat (20) @(posedge aclk);
      check("ramp count", ramps, 12);
      check("bad ramp lengths", bad_runs, 0);
      check("final level", shaper_state.level, 1'b0);
      rd(OFS_STATUS, 32'h100, RESP_OKAY);
    end
    $display("test shaper ramps finished");
    for (int i = 0; i < 4; i++) begin
      wr(OFS_SHAPER, 32'(ex[i] << 8 | dv[i]), RESP_OKAY);
      repeat (3) tick_gap(n);
      check("tick period", n, dv[i] << (7 - ex[i]));
    end
    $display("test modulator clock finished");
    for (int i = 0; i < 2; i++) begin
      wr(OFS_SHAPER, wv[i], RESP_OKAY);
      rd(OFS_SHAPER, wv[i], RESP_OKAY);
      repeat (2) @(posedge aclk);
      check("slope code", slope_code, wv[i][SHP_SLOPE_LSB +: SLOPE_W]);
      check("atten code", atten_code, wv[i][SHP_ATTEN_LSB +: ATTEN_W]);
      check("filter code", filter_code, wv[i][SHP_FILT_LSB +: FILT_W]);
    end
    $display("test shaper fields finished");
    test_done;
  end
endmodule // testbench
